// ### design/ossq_params.svh
// Constants for the operating state switch sequencer
// Behaviour
// - Regulator bit 6: 0 normal, 1 low-power
// - Protect bit 0 gates flash mode writes
// - Each button press advances one state
// - States 0-3 follow the measurement table
// - State 3 to HS or error; 7 wraps
// - Core halts until button interrupt wakes; code halts only while measurement mode is active
// - Only main clock runs; peripherals stopped; code stops them only in measurement mode
// - GPIO driven low, debug pin stays input; code enables the outputs only in measurement mode
`ifndef OSSQ_PARAMS_SVH
`define OSSQ_PARAMS_SVH
`define OSSQ_ADDR_W          4
`define OSSQ_OFS_REG_MODE    4'h0
`define OSSQ_OFS_WPROT       4'h1
`define OSSQ_OFS_FLASH_OPERATING_MODE_SELECT      4'h2
`define OSSQ_OFS_STATUS      4'h3
`define OSSQ_OFS_CTRL        4'h4
`define OSSQ_OFS_VOLT        4'h5
`define OSSQ_OFS_TARGET      4'h6
`define OSSQ_BIT_LP_SEL      6
`define OSSQ_BIT_WPERMIT     0
`define OSSQ_RST_REG_MODE    8'h00
`define OSSQ_RST_WPROT       8'h00
`define OSSQ_RST_FLASH_OPERATING_MODE_SELECT      2'h0
`define OSSQ_GPIO_W          8
`define OSSQ_DEBUG_PIN       0
`define OSSQ_ZERO8           8'h00
`define OSSQ_MHZ_4           5'h04
`define OSSQ_MHZ_8           5'h08
`define OSSQ_MHZ_16          5'h10
`define OSSQ_MHZ_1           5'h01
`endif

// ### design/ossq_pkg.sv
// Types for the operating state switch sequencer
package ossq_pkg;
    typedef enum logic [1:0] {
        OSSQ_FM_LV,
        OSSQ_FM_LS,
        OSSQ_FM_HS,
        OSSQ_FM_LP
    } ossq_flash_operating_mode_select_t;

    typedef enum logic [3:0] {
        OSSQ_ST0, OSSQ_ST1, OSSQ_ST2, OSSQ_ST3, OSSQ_ST4, OSSQ_ST4_ERR,
        OSSQ_ST5, OSSQ_ST6, OSSQ_ST7
    } ossq_state_t;

    typedef struct packed {
        ossq_flash_operating_mode_select_t mode;
        logic         use_middle_osc;
        logic         low_power_reg;
        logic [4:0]   freq_mhz;
    } ossq_setting_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ossq_bus_t;
endpackage : ossq_pkg

// ### design/ossq_edge_sync.sv
// Two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ps
module ossq_edge_sync (
    input  wire logic clk_sys_in,
    input  wire logic arst_n_in,
    input  wire logic async_in,
    output logic      pulse_out
);
    logic meta;
    logic sync;
    logic sync_d;

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta   <= 1'b0;
            sync   <= 1'b0;
            sync_d <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            meta   <= async_in;
            sync   <= meta;
            sync_d <= sync;
            pulse_out <= sync & ~sync_d;
        end
    end
endmodule : ossq_edge_sync

// ### design/ossq_sequencer.sv
// Operating state switch sequencer top level
`timescale 1ns/1ps
`include "ossq_params.svh"
module ossq_sequencer
    import ossq_pkg::*;
(
    input  wire logic                     clk_sys_in,
    input  wire logic                     arst_n_in,
    input  wire logic                     button_irq_in,
    input  wire logic [`OSSQ_ADDR_W-1:0]  addr_in,
    input  wire logic [7:0]               wdata_in,
    input  wire logic                     wr_in,
    input  wire logic                     rd_in,
    input  wire logic                     meas_mode_in,
    input  wire logic                     volt_ok_in,
    output logic [7:0]                    rdata_out,
    output logic [1:0]                    flash_mode_out,
    output logic                          regulator_lp_out,
    output logic                          middle_osc_sel_out,
    output logic [4:0]                    freq_mhz_out,
    output logic [3:0]                    state_out,
    output logic                          halt_out,
    output logic                          periph_stop_out,
    output logic [`OSSQ_GPIO_W-1:0]       gpio_out,
    output logic [`OSSQ_GPIO_W-1:0]       gpio_oe_out
);
    ////////////////////////////////////////////////////////////////////
    ossq_bus_t     bus;
    ossq_state_t   state;
    ossq_state_t   next_state;
    ossq_setting_t set_now;
    logic [7:0]    regulator_mode_control;
    logic [7:0]    flash_mode_write_protect;
    ossq_flash_operating_mode_select_t  flash_operating_mode_select;
    logic          meas_en;
    logic          press;
    logic          wr_reg_mode;
    logic          wr_wprot;
    logic          wr_flash_operating_mode_select;
    logic          wr_ctrl;
    logic          flash_mode_write_permit;
    logic          regulator_low_power_select;
    logic [7:0]    next_rdata;
    logic [7:0]    status_word;
    logic          volt_s1;
    logic          volt_s2;
    logic          meas_s1;
    logic          meas_pin;
    logic          halted;
    logic          meas_active;
    logic [7:0]    target_word;
    logic [7:0]    next_gpio_oe;

    assign bus = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};

    // Button is asynchronous: two flops, then one pulse per press
    ossq_edge_sync u_button (
        .clk_sys_in (clk_sys_in),
        .arst_n_in  (arst_n_in),
        .async_in   (button_irq_in),
        .pulse_out  (press)
    );

    ////////////////////////////////////////////////////////////////////
    // Register decode
    assign wr_reg_mode = bus.wr && bus.addr == `OSSQ_OFS_REG_MODE;
    assign wr_wprot    = bus.wr && bus.addr == `OSSQ_OFS_WPROT;
    assign wr_flash_operating_mode_select   = bus.wr && bus.addr == `OSSQ_OFS_FLASH_OPERATING_MODE_SELECT;
    assign wr_ctrl     = bus.wr && bus.addr == `OSSQ_OFS_CTRL;
    assign flash_mode_write_permit =
        flash_mode_write_protect[`OSSQ_BIT_WPERMIT];
    assign regulator_low_power_select =
        regulator_mode_control[`OSSQ_BIT_LP_SEL];
    assign status_word = {halted, meas_en, 2'h0, state};
    // Settings the current state stands for, read back by software
    assign target_word = {set_now.low_power_reg, set_now.use_middle_osc,
                          4'h0, set_now.mode};

    // Read data stand one cycle after the strobe, else zero
    assign next_rdata =
        !bus.rd ? `OSSQ_ZERO8 :
        bus.addr == `OSSQ_OFS_REG_MODE ? regulator_mode_control :
        bus.addr == `OSSQ_OFS_WPROT    ? flash_mode_write_protect :
        bus.addr == `OSSQ_OFS_FLASH_OPERATING_MODE_SELECT   ?
            {6'h00, flash_operating_mode_select} :
        bus.addr == `OSSQ_OFS_STATUS   ? status_word :
        bus.addr == `OSSQ_OFS_CTRL     ? {7'h00, meas_en} :
        bus.addr == `OSSQ_OFS_VOLT     ? {7'h00, volt_s2} :
        bus.addr == `OSSQ_OFS_TARGET   ? target_word :
        `OSSQ_ZERO8;

    ////////////////////////////////////////////////////////////////////
    // Measurement mode: pin or control bit
    assign meas_active  = meas_en | meas_pin;
    assign next_gpio_oe = meas_active ?
        ~(8'h01 << `OSSQ_DEBUG_PIN) : `OSSQ_ZERO8;

    ////////////////////////////////////////////////////////////////////
    // State sequence
    always_comb begin
        next_state = state;
        if (press) begin
            case (state)
                OSSQ_ST0:     next_state = OSSQ_ST1;
                OSSQ_ST1:     next_state = OSSQ_ST2;
                OSSQ_ST2:     next_state = OSSQ_ST3;
                // Supply level decides the fast branch
                OSSQ_ST3:     next_state = volt_s2 ? OSSQ_ST4
                                                   : OSSQ_ST4_ERR;
                OSSQ_ST4:     next_state = OSSQ_ST5;
                OSSQ_ST4_ERR: next_state = OSSQ_ST5;
                OSSQ_ST5:     next_state = OSSQ_ST6;
                OSSQ_ST6:     next_state = OSSQ_ST7;
                OSSQ_ST7:     next_state = OSSQ_ST0;
                default:      next_state = OSSQ_ST0;
            endcase
        end
    end

    // Setting table per state
    // Software applies mode and regulator; oscillator and frequency drive outputs
    always_comb begin
        case (state)
            OSSQ_ST0: set_now = '{OSSQ_FM_LV, 1'b0, 1'b0, `OSSQ_MHZ_4};
            OSSQ_ST1: set_now = '{OSSQ_FM_LV, 1'b1, 1'b0, `OSSQ_MHZ_4};
            OSSQ_ST2: set_now = '{OSSQ_FM_LS, 1'b1, 1'b1, `OSSQ_MHZ_4};
            OSSQ_ST4: set_now = '{OSSQ_FM_HS, 1'b0, 1'b0, `OSSQ_MHZ_16};
            OSSQ_ST6: set_now = '{OSSQ_FM_LP, 1'b1, 1'b0, `OSSQ_MHZ_1};
            default:  set_now = '{OSSQ_FM_LS, 1'b0, 1'b0, `OSSQ_MHZ_8};
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Synchronisers for pin levels
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            volt_s1 <= 1'b0;
            volt_s2 <= 1'b0;
            meas_s1 <= 1'b0;
            meas_pin <= 1'b0;
        end else begin
            volt_s1 <= volt_ok_in;
            volt_s2 <= volt_s1;
            meas_s1 <= meas_mode_in;
            meas_pin <= meas_s1;
        end
    end

    // Registers
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            regulator_mode_control   <= `OSSQ_RST_REG_MODE;
            flash_mode_write_protect <= `OSSQ_RST_WPROT;
            meas_en                  <= 1'b0;
            rdata_out                <= `OSSQ_ZERO8;
        end else begin
            rdata_out <= next_rdata;
            // Only the defined bit of each register is stored
            if (wr_reg_mode) begin
                regulator_mode_control <=
                    wdata_in & (8'h01 << `OSSQ_BIT_LP_SEL);
            end
            if (wr_wprot) begin
                flash_mode_write_protect <=
                    wdata_in & (8'h01 << `OSSQ_BIT_WPERMIT);
            end
            if (wr_ctrl) begin
                meas_en <= wdata_in[0];
            end
        end
    end

    // Flash mode select, state and halt flag
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state                       <= OSSQ_ST0;
            flash_operating_mode_select <= OSSQ_FM_LV;
            halted                      <= 1'b0;
        end else begin
            state <= next_state;
            // A protected write is dropped, not held for later
            if (wr_flash_operating_mode_select && flash_mode_write_permit) begin
                flash_operating_mode_select <= ossq_flash_operating_mode_select_t'(wdata_in[1:0]);
            end
            // Wake on the press; halt again from the next cycle
            if (press || !meas_active) begin
                halted <= 1'b0;
            end else begin
                halted <= 1'b1;
            end
        end
    end

    // Flash and clock settings
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flash_mode_out     <= `OSSQ_RST_FLASH_OPERATING_MODE_SELECT;
            regulator_lp_out   <= 1'b0;
            middle_osc_sel_out <= 1'b0;
            freq_mhz_out       <= `OSSQ_MHZ_4;
            state_out          <= OSSQ_ST0;
        end else begin
            flash_mode_out     <= flash_operating_mode_select;
            regulator_lp_out   <= regulator_low_power_select;
            middle_osc_sel_out <= set_now.use_middle_osc;
            freq_mhz_out       <= set_now.freq_mhz;
            state_out          <= state;
        end
    end

    // Core and pin levels for current measurement
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            halt_out        <= 1'b0;
            periph_stop_out <= 1'b0;
            gpio_out        <= `OSSQ_ZERO8;
            gpio_oe_out     <= `OSSQ_ZERO8;
        end else begin
            halt_out        <= halted;
            periph_stop_out <= meas_active;
            gpio_out        <= `OSSQ_ZERO8;
            gpio_oe_out     <= next_gpio_oe;
        end
    end
endmodule : ossq_sequencer

// ### verif/ossq_sequencer_sva.sv
// Assertions for the operating state switch sequencer
`timescale 1ns/1ps
module ossq_sequencer_sva (
    input wire logic       clk_sys_in,
    input wire logic       arst_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       meas_mode_in,
    input wire logic [1:0] flash_mode_out,
    input wire logic       regulator_lp_out,
    input wire logic [3:0] state_out,
    input wire logic       periph_stop_out,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe_out
);
default clocking @(posedge clk_sys_in); endclocking
default disable iff (!arst_n_in);
logic prot_q;
////////////////////////////////////////////////////////////////////////
// Mirror of the write permit bit
always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) prot_q <= 1'b0;
    else if (wr_in && addr_in == 4'h1) prot_q <= wdata_in[0];
end
////////////////////////////////////////////////////////////////////////
reg_mode_a: assert property (
    wr_in && addr_in == 4'h0
    |-> ##2 regulator_lp_out == $past(wdata_in[6], 2))
    else $error("regulator bit wrong");
prot_block_a: assert property (
    wr_in && addr_in == 4'h2 && !prot_q |-> ##2 $stable(flash_mode_out))
    else $error("protected write took effect");
prot_pass_a: assert property (
    wr_in && addr_in == 4'h2 && prot_q
    |-> ##2 flash_mode_out == $past(wdata_in[1:0], 2))
    else $error("permitted write lost");
step_one_a: assert property (
    $changed(state_out) && $past(state_out) < 4'h3
    |-> state_out == $past(state_out) + 4'h1)
    else $error("state skipped");
hs_branch_a: assert property (
    $changed(state_out) && $past(state_out) == 4'h3
    |-> state_out inside {4'h4, 4'h5})
    else $error("bad branch from state 3");
wrap_a: assert property (
    $changed(state_out) && $past(state_out) == 4'h8 |-> state_out == 4'h0)
    else $error("no wrap to state 0");
one_press_a: assert property (
    $changed(state_out) |=> $stable(state_out) [*2])
    else $error("double advance");
meas_stop_a: assert property (
    meas_mode_in [*4] |-> periph_stop_out && gpio_oe_out == 8'hfe)
    else $error("measurement outputs wrong");
gpio_low_a: assert property (gpio_out == 8'h00)
    else $error("gpio not low");
endmodule : ossq_sequencer_sva
bind ossq_sequencer ossq_sequencer_sva i_ossq_sequencer_sva (.*);

// ### verif/test_ossq_sequencer.sv
// Testbench for the operating state switch sequencer
`timescale 1ns/1ps
module test_ossq_sequencer;
logic clk_sys_in = 1'b0;
logic arst_n_in = 1'b0;
logic button_irq_in = 1'b0;
logic wr_in = 1'b0;
logic rd_in = 1'b0;
logic meas_mode_in = 1'b0;
logic volt_ok_in = 1'b1;
logic [3:0] addr_in = 4'h0;
logic [7:0] wdata_in = 8'h00;
logic [7:0] rdata_out, gpio_out, gpio_oe_out;
logic [1:0] flash_mode_out;
logic [4:0] freq_mhz_out;
logic [3:0] state_out;
logic regulator_lp_out, middle_osc_sel_out, halt_out, periph_stop_out;
int fails = 0;
int total_checks = 0;
logic [4:0] fq [9] = '{5'h04, 5'h04, 5'h04, 5'h08, 5'h10, 5'h08, 5'h08,
                       5'h01, 5'h08};
logic [8:0] mid = 9'h086;
logic [8:0] lpr = 9'h004;
logic [1:0] fm [9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1, 2'h3,
                       2'h1};
ossq_sequencer i_ossq_sequencer (.*);
initial begin
    forever #20 clk_sys_in = ~clk_sys_in;
end
////////////////////////////////////////////////////////////////////////
task automatic give_verdict;
    if (fails == 0 && total_checks > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask : give_verdict
task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
        fails++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
endtask : chk
task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
endtask : wr
task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 chk("rdata", e, rdata_out);
endtask : rd
// Long press, then settings of the expected state
task automatic press(input logic [3:0] e);
    @(posedge clk_sys_in);
    button_irq_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    button_irq_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    #1 chk("state", {4'h0, e}, {4'h0, state_out});
    chk("freq", {3'h0, fq[e]}, {3'h0, freq_mhz_out});
    chk("midosc", {7'h0, mid[e]}, {7'h0, middle_osc_sel_out});
    rd(4'h6, {lpr[e], mid[e], 4'h0, fm[e]});
endtask : press
////////////////////////////////////////////////////////////////////////
initial begin
    logic [3:0] e;
    repeat (5) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    rd(4'h3, 8'h00);
    chk("freq", 8'h04, {3'h0, freq_mhz_out});
    wr(4'h0, 8'hff);
    chk("reglp", 8'h01, {7'h0, regulator_lp_out});
    rd(4'h0, 8'h40);
    wr(4'h0, 8'h00);
    chk("reglp", 8'h00, {7'h0, regulator_lp_out});
    wr(4'h2, 8'h01);
    chk("flash_operating_mode_select", 8'h00, {6'h0, flash_mode_out});
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h01);
    wr(4'h2, 8'h01);
    chk("flash_operating_mode_select", 8'h01, {6'h0, flash_mode_out});
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h00);
    rd(4'hf, 8'h00);
    for (int v = 1; v >= 0; v--) begin
        @(posedge clk_sys_in);
        volt_ok_in <= v[0];
        for (int i = 0; i < 8; i++) begin
            e = i < 3 ? 4'(i + 1) : i == 3 ? (v == 1 ? 4'h4 : 4'h5)
                : 4'((i + 2) % 9);
            press(e);
        end
    end
    @(posedge clk_sys_in);
    meas_mode_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    #1 chk("oe", 8'hfe, gpio_oe_out);
    chk("gpio", 8'h00, gpio_out);
    chk("pstop", 8'h01, {7'h0, periph_stop_out});
    chk("halt", 8'h01, {7'h0, halt_out});
    rd(4'h3, 8'h80);
    press(4'h1);
    @(posedge clk_sys_in);
    meas_mode_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    #1 chk("pstop", 8'h00, {7'h0, periph_stop_out});
    chk("oe", 8'h00, gpio_oe_out);
    wr(4'h4, 8'h01);
    repeat (4) @(posedge clk_sys_in);
    #1 chk("oe", 8'hfe, gpio_oe_out);
    wr(4'h4, 8'h00);
    give_verdict();
end
endmodule : test_ossq_sequencer
